// ===== verilog/dukp_update_keying.sv
// Update strobe, programming ports and keying pins of the synthesizer
`timescale 1ns/10ps
module dukp_update_keying (
  input wire logic clk,
  input wire logic rst,
  input wire logic serialParallelSelect,
  input wire logic writeSerialClockPin,
  input wire logic readChipSelectPinN,
  input wire logic [5:0] addrIn,
  output logic serialDataOut,
  output logic serialDataOeN,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOeN,
  input wire logic registerUpdateStrobeIn,
  output logic registerUpdateStrobeOut,
  output logic registerUpdateStrobeOeN,
  input wire logic keyingSelectHoldPin,
  input wire logic shapedKeyingPin,
  output logic [47:0] tuningWord,
  output logic [47:0] phaseAccum,
  output logic [13:0] phaseOffset,
  output logic [11:0] amplitude,
  output logic [11:0] quadratureDacOutput
);

  typedef enum logic [0:0] {SER_INSTR, SER_DATA} dukp_ser_e;

  typedef struct packed {
    logic [dukp_pkg::SYN_W-1:0] s1;
    logic [dukp_pkg::SYN_W-1:0] s2;
    logic [dukp_pkg::SYN_W-1:0] s3;
    dukp_ser_e ser;
    logic [7:0] shiftIn;
    logic [2:0] bitCnt;
    logic [5:0] serAddr;
    logic serRead;
    logic sdo;
    logic sdoOeN;
    logic [7:0] dOut;
    logic dOeN;
    logic [3:0] pulseLeft;
    logic updOut;
    logic updOeN;
    logic [7:0] updTimer;
    logic [47:0] chirpAcc;
    logic [47:0] tuning;
    logic [47:0] phaseAcc;
    logic [13:0] phOff;
    logic [11:0] amp;
    logic [7:0] rampCnt;
    logic [11:0] qOut;
  } dukp_state_s;

  dukp_state_s st_d;
  dukp_state_s st_q;

  // ----------------------------------------------------------------
  // Field extraction from the active register image
  // ----------------------------------------------------------------
  function automatic logic [47:0] regField(input logic [dukp_pkg::FLAT_W-1:0] flat, input int base, input int nbytes);
    logic [47:0] r;
    r = '0;
    for (int i = 0; i < dukp_pkg::FREQ_BYTES; i++)
      if (i < nbytes)
        r = {r[39:0], flat[(base + i) * dukp_pkg::DATA_W +: dukp_pkg::DATA_W]};
    return r;
  endfunction

  logic memWe;
  logic [5:0] memWaddr;
  logic [7:0] memWdata;
  logic [5:0] memRaddr;
  logic [7:0] memRdata;
  logic commit;
  logic [dukp_pkg::FLAT_W-1:0] act;
  logic [47:0] f1, f2, delta, ph1W, ph2W, periodW, rateW, qdacW, ctrlW;
  logic [47:0] phaseSum;
  logic [7:0] ctrl;
  logic [2:0] mode;
  logic parMode, wrRise, sclkRise, sclkFall, rdLvl, ioRst, sdi, updRise, key, shaped_keying_pin;
  logic intUpd, oskEn, qExt, oskStep;
  logic [5:0] pAddr;
  logic [7:0] pData;

  dukp_prog_mem u_mem (
    .clk(clk),
    .rst(rst),
    .wrEn(memWe),
    .wrAddr(memWaddr),
    .wrData(memWdata),
    .rdAddr(memRaddr),
    .commit(commit),
    .rdData(memRdata),
    .activeFlat(act)
  );

  assign f1 = regField(act, dukp_pkg::ADDR_FREQ1, dukp_pkg::FREQ_BYTES);
  assign f2 = regField(act, dukp_pkg::ADDR_FREQ2, dukp_pkg::FREQ_BYTES);
  assign delta = regField(act, dukp_pkg::ADDR_DELTA, dukp_pkg::FREQ_BYTES);
  assign ph1W = regField(act, dukp_pkg::ADDR_PHASE1, dukp_pkg::PHASE_BYTES);
  assign ph2W = regField(act, dukp_pkg::ADDR_PHASE2, dukp_pkg::PHASE_BYTES);
  assign qdacW = regField(act, dukp_pkg::ADDR_QDAC, dukp_pkg::PHASE_BYTES);
  assign periodW = regField(act, dukp_pkg::ADDR_UPD_PERIOD, 1);
  assign rateW = regField(act, dukp_pkg::ADDR_RAMP_RATE, 1);
  assign ctrlW = regField(act, dukp_pkg::ADDR_CTRL, 1);
  assign ctrl = ctrlW[7:0];
  assign mode = ctrl[dukp_pkg::CTRL_MODE_LSB +: dukp_pkg::MODE_W];
  assign intUpd = ctrl[dukp_pkg::CTRL_INT_UPD_BIT];
  assign oskEn = ctrl[dukp_pkg::CTRL_OSK_EN_BIT];
  assign qExt = ctrl[dukp_pkg::CTRL_QDAC_EXT_BIT];

  // ----------------------------------------------------------------
  // Synchronised pin view (second stage and its delayed copy only)
  // ----------------------------------------------------------------
  assign parMode = st_q.s2[dukp_pkg::SYN_SP];
  assign rdLvl = st_q.s2[dukp_pkg::SYN_RD];
  assign wrRise = st_q.s2[dukp_pkg::SYN_WR] & ~st_q.s3[dukp_pkg::SYN_WR];
  assign sclkRise = wrRise;
  assign sclkFall = ~st_q.s2[dukp_pkg::SYN_WR] & st_q.s3[dukp_pkg::SYN_WR];
  assign pAddr = st_q.s2[dukp_pkg::SYN_ADDR_LSB +: dukp_pkg::ADDR_W];
  assign pData = st_q.s2[dukp_pkg::SYN_DATA_LSB +: dukp_pkg::DATA_W];
  assign ioRst = pAddr[dukp_pkg::ADDR_IORST_BIT];
  assign sdi = pAddr[dukp_pkg::ADDR_SDI_BIT];
  assign updRise = st_q.s2[dukp_pkg::SYN_UPD] & ~st_q.s3[dukp_pkg::SYN_UPD];
  assign key = st_q.s2[dukp_pkg::SYN_KEY];
  assign shaped_keying_pin = st_q.s2[dukp_pkg::SYN_OSK];
  assign oskStep = oskEn && (st_q.rampCnt >= rateW[7:0]);
  assign phaseSum = st_q.phaseAcc + {st_q.phOff, {dukp_pkg::PHASE_PAD{1'b0}}};

  // Internal timer or external rising edge moves buffers to active
  assign commit = intUpd ? (st_q.updTimer == dukp_pkg::BYTE_ZERO) : updRise;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = {serialParallelSelect, writeSerialClockPin, readChipSelectPinN, addrIn, dataIn,
               registerUpdateStrobeIn, keyingSelectHoldPin, shapedKeyingPin};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    memWe = 1'b0;
    memWaddr = pAddr;
    memWdata = pData;
    memRaddr = pAddr;
    st_d.dOeN = 1'b1;
    st_d.sdoOeN = 1'b1;

    // ------------------------------------------------------------
    // Programming ports
    // ------------------------------------------------------------
    if (parMode)
    begin
      st_d.ser = SER_INSTR;
      st_d.bitCnt = 3'h0;
      memWe = wrRise;
      if (!rdLvl)
      begin
        st_d.dOeN = 1'b0;
        st_d.dOut = memRdata;
      end
    end
    else if (ioRst || rdLvl)
    begin
      st_d.ser = SER_INSTR;
      st_d.bitCnt = 3'h0;
    end
    else
    begin
      if (st_q.ser == SER_DATA && st_q.serRead)
      begin
        st_d.sdoOeN = 1'b0;
        memRaddr = st_q.serAddr;
      end
      if (sclkFall)
        st_d.sdo = memRdata[~st_q.bitCnt];
      if (sclkRise)
      begin
        st_d.shiftIn = {st_q.shiftIn[6:0], sdi};
        st_d.bitCnt = st_q.bitCnt + 3'h1;
        if (st_q.bitCnt == dukp_pkg::BIT_LAST)
        begin
          case (st_q.ser)
            SER_INSTR:
            begin
              st_d.serAddr = st_d.shiftIn[5:0];
              st_d.serRead = st_d.shiftIn[dukp_pkg::SER_READ_BIT];
              st_d.ser = SER_DATA;
            end
            SER_DATA:
            begin
              memWe = !st_q.serRead;
              memWaddr = st_q.serAddr;
              memWdata = st_d.shiftIn;
              st_d.serAddr = st_q.serAddr + 6'h01;
            end
            default:
              st_d.ser = SER_INSTR;
          endcase
        end
      end
    end

    // ------------------------------------------------------------
    // Update strobe pin
    // ------------------------------------------------------------
    st_d.updOeN = ~intUpd;
    if (intUpd && st_q.updTimer == dukp_pkg::BYTE_ZERO)
    begin
      st_d.updTimer = periodW[7:0];
      st_d.pulseLeft = dukp_pkg::UPD_PULSE_CYCLES;
    end
    else
    begin
      if (intUpd)
        st_d.updTimer = st_q.updTimer - 8'h01;
      if (st_q.pulseLeft != 4'h0)
        st_d.pulseLeft = st_q.pulseLeft - 4'h1;
    end
    st_d.updOut = (st_d.pulseLeft != 4'h0);

    // ------------------------------------------------------------
    // Frequency, phase and keying
    // ------------------------------------------------------------
    if (mode == dukp_pkg::MODE_CHIRP)
    begin
      if (!key)
        st_d.chirpAcc = st_q.chirpAcc + delta;
      st_d.tuning = f1 + st_d.chirpAcc;
    end
    else
    begin
      st_d.chirpAcc = '0;
      st_d.tuning = (mode == dukp_pkg::MODE_FSK && key) ? f2 : f1;
    end
    st_d.phOff = (mode == dukp_pkg::MODE_BPSK && key) ? ph2W[13:0] : ph1W[13:0];
    st_d.phaseAcc = st_q.phaseAcc + st_q.tuning;

    if (!oskEn)
    begin
      st_d.amp = dukp_pkg::AMP_FULL;
      st_d.rampCnt = 8'h00;
    end
    else if (oskStep)
    begin
      st_d.rampCnt = 8'h00;
      if (shaped_keying_pin && st_q.amp != dukp_pkg::AMP_FULL)
        st_d.amp = st_q.amp + 12'h001;
      else if (!shaped_keying_pin && st_q.amp != dukp_pkg::AMP_ZERO)
        st_d.amp = st_q.amp - 12'h001;
    end
    else
      st_d.rampCnt = st_q.rampCnt + 8'h01;

    st_d.qOut = qExt ? qdacW[11:0] : phaseSum[47:36];

    if (rst)
    begin
      st_d = '0;
      st_d.sdoOeN = 1'b1;
      st_d.dOeN = 1'b1;
    end
  end

  always_ff @(posedge clk)
    st_q <= st_d;

  assign serialDataOut = st_q.sdo;
  assign serialDataOeN = st_q.sdoOeN;
  assign dataOut = st_q.dOut;
  assign dataOeN = st_q.dOeN;
  assign registerUpdateStrobeOut = st_q.updOut;
  assign registerUpdateStrobeOeN = st_q.updOeN;
  assign tuningWord = st_q.tuning;
  assign phaseAccum = st_q.phaseAcc;
  assign phaseOffset = st_q.phOff;
  assign amplitude = st_q.amp;
  assign quadratureDacOutput = st_q.qOut;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seqUpdPulse;
    st_q.updOut[*8];
  endsequence

  sequence seqSerialIdle;
    st_q.ser == SER_INSTR && st_q.bitCnt == 3'h0;
  endsequence

  chk_input_update_commit: assert property (!intUpd && updRise |-> commit)
    else $error("input update edge did not commit");
  chk_update_pulse_width: assert property ($rose(st_q.updOut) |-> seqUpdPulse)
    else $error("update pulse shorter than eight cycles");
  chk_update_pin_dir: assert property (!intUpd |=> st_q.updOeN)
    else $error("update pin driven while input");
  chk_parallel_buffer_write: assert property (parMode && wrRise |-> memWe && memWaddr == pAddr)
    else $error("parallel write not sent to buffer");
  chk_serial_bit_capture: assert property (!parMode && !rdLvl && !ioRst && sclkRise |=> st_q.shiftIn[0] == $past(sdi))
    else $error("serial bit not captured");
  chk_parallel_no_sdo: assert property (parMode |=> st_q.sdoOeN)
    else $error("serial output driven in parallel mode");
  chk_parallel_read_drive: assert property (parMode && !rdLvl ##1 parMode && !rdLvl |=> !st_q.dOeN && st_q.dOut == $past(memRdata))
    else $error("read strobe did not drive bus");
  chk_cs_high_idle: assert property (!parMode && rdLvl |=> seqSerialIdle)
    else $error("serial port active with select high");
  chk_fsk_select: assert property (mode == dukp_pkg::MODE_FSK && key |=> st_q.tuning == $past(f2))
    else $error("fsk high did not pick second word");
  chk_bpsk_select: assert property (mode == dukp_pkg::MODE_BPSK && !key |=> st_q.phOff == $past(ph1W[13:0]))
    else $error("bpsk low did not pick first phase");
  chk_chirp_hold: assert property (mode == dukp_pkg::MODE_CHIRP && key |=> $stable(st_q.chirpAcc))
    else $error("chirp accumulator moved during hold");
  chk_chirp_run: assert property (mode == dukp_pkg::MODE_CHIRP && !key |=> st_q.chirpAcc == $past(st_q.chirpAcc + delta))
    else $error("chirp did not advance");
  chk_osk_disabled: assert property (!oskEn |=> st_q.amp == dukp_pkg::AMP_FULL)
    else $error("amplitude moved with keying disabled");
  chk_osk_ramp_up: assert property (oskStep && shaped_keying_pin && st_q.amp != dukp_pkg::AMP_FULL |=> st_q.amp == $past(st_q.amp) + 12'h001)
    else $error("amplitude did not ramp up");
  chk_osk_ramp_down: assert property (oskStep && !shaped_keying_pin && st_q.amp != dukp_pkg::AMP_ZERO |=> st_q.amp == $past(st_q.amp) - 12'h001)
    else $error("amplitude did not ramp down");
  chk_quad_external: assert property (qExt |=> st_q.qOut == $past(qdacW[11:0]))
    else $error("quadrature channel ignored user value");
  chk_io_reset_idle: assert property (!parMode && ioRst |=> seqSerialIdle)
    else $error("serial reset did not idle the port");
  chk_active_hold: assert property (!commit |=> $stable(act))
    else $error("active registers changed without update");

endmodule

// ===== verilog/dukp_pkg.sv
// Constants shared by the update, keying and programming-port logic
package dukp_pkg;

  // ----------------------------------------------------------------
  // Register space
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 64;
  localparam int FLAT_W = NUM_REGS * DATA_W;
  localparam int FREQ_W = 48;
  localparam int FREQ_BYTES = 6;
  localparam int PHASE_W = 14;
  localparam int PHASE_BYTES = 2;
  localparam int AMP_W = 12;
  localparam int PHASE_PAD = FREQ_W - PHASE_W;

  localparam logic [5:0] ADDR_PHASE1 = 6'h00;
  localparam logic [5:0] ADDR_PHASE2 = 6'h02;
  localparam logic [5:0] ADDR_FREQ1 = 6'h04;
  localparam logic [5:0] ADDR_FREQ2 = 6'h0a;
  localparam logic [5:0] ADDR_DELTA = 6'h10;
  localparam logic [5:0] ADDR_UPD_PERIOD = 6'h16;
  localparam logic [5:0] ADDR_RAMP_RATE = 6'h1a;
  localparam logic [5:0] ADDR_QDAC = 6'h1b;
  localparam logic [5:0] ADDR_CTRL = 6'h1f;

  // ----------------------------------------------------------------
  // Control byte fields and modes
  // ----------------------------------------------------------------
  localparam int CTRL_INT_UPD_BIT = 0;
  localparam int CTRL_OSK_EN_BIT = 1;
  localparam int CTRL_QDAC_EXT_BIT = 2;
  localparam int CTRL_MODE_LSB = 3;
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_SINGLE = 3'h0;
  localparam logic [2:0] MODE_FSK = 3'h1;
  localparam logic [2:0] MODE_CHIRP = 3'h3;
  localparam logic [2:0] MODE_BPSK = 3'h4;

  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] UPD_PERIOD_RESET = 8'h3f;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [11:0] AMP_FULL = 12'hfff;
  localparam logic [11:0] AMP_ZERO = 12'h000;

  // ----------------------------------------------------------------
  // Timing and serial framing
  // ----------------------------------------------------------------
  localparam logic [3:0] UPD_PULSE_CYCLES = 4'h8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int SER_READ_BIT = 7;
  localparam int ADDR_IORST_BIT = 2;
  localparam int ADDR_SDI_BIT = 0;

  // Synchroniser bundle layout
  localparam int SYN_W = 20;
  localparam int SYN_SP = 19;
  localparam int SYN_WR = 18;
  localparam int SYN_RD = 17;
  localparam int SYN_ADDR_LSB = 11;
  localparam int SYN_DATA_LSB = 3;
  localparam int SYN_UPD = 2;
  localparam int SYN_KEY = 1;
  localparam int SYN_OSK = 0;

  function automatic logic [7:0] regDefault(input logic [5:0] a);
    if (a == ADDR_CTRL)
      return CTRL_RESET;
    else if (a == ADDR_UPD_PERIOD)
      return UPD_PERIOD_RESET;
    else
      return BYTE_ZERO;
  endfunction

endpackage

// ===== verilog/dukp_prog_mem.sv
// Interface buffers and active programming registers
`timescale 1ns/10ps
module dukp_prog_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [5:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [5:0] rdAddr,
  input wire logic commit,
  output logic [7:0] rdData,
  output logic [dukp_pkg::FLAT_W-1:0] activeFlat
);

  typedef struct packed {
    logic [dukp_pkg::NUM_REGS-1:0][7:0] bufRegs;
    logic [dukp_pkg::NUM_REGS-1:0][7:0] actRegs;
    logic [7:0] rd;
  } dukp_mem_s;

  dukp_mem_s st_d;
  dukp_mem_s st_q;

  always_comb
  begin
    st_d = st_q;
    // Commit takes the buffer as it stood before this cycle's write
    if (commit)
      st_d.actRegs = st_q.bufRegs;
    if (wrEn)
      st_d.bufRegs[wrAddr] = wrData;
    st_d.rd = st_q.actRegs[rdAddr];
    if (rst)
    begin
      for (int i = 0; i < dukp_pkg::NUM_REGS; i++)
      begin
        st_d.bufRegs[i] = dukp_pkg::regDefault(6'(i));
        st_d.actRegs[i] = dukp_pkg::regDefault(6'(i));
      end
      st_d.rd = dukp_pkg::BYTE_ZERO;
    end
  end

  always_ff @(posedge clk)
    st_q <= st_d;

  assign rdData = st_q.rd;
  assign activeFlat = st_q.actRegs;

endmodule

// ===== verif/dukp_host_model.sv
// Host controller model driving the programming and keying pins
`timescale 1ns/10ps
module dukp_host_model (
  input wire logic clk,
  input wire logic [7:0] dataRd,
  output logic selectPin,
  output logic wrPin,
  output logic csPinN,
  output logic [5:0] addrPin,
  output logic [7:0] dataPin,
  output logic updPin,
  output logic keyPin,
  output logic oskPin
);
  initial
  begin
    selectPin = 1'b1;
    wrPin = 1'b0;
    csPinN = 1'b1;
    addrPin = 6'h00;
    dataPin = 8'h00;
    updPin = 1'b0;
    keyPin = 1'b0;
    oskPin = 1'b0;
  end

  // ----------------------------------------------------------------
  // Pin sequences
  // ----------------------------------------------------------------
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic parWrite(input logic [5:0] a, input logic [7:0] d);
    addrPin = a;
    dataPin = d;
    ticks(3);
    wrPin = 1'b1;
    ticks(3);
    wrPin = 1'b0;
    ticks(1);
    dataPin = ~d;
    ticks(2);
  endtask

  task automatic parWord(input logic [5:0] a, input logic [47:0] w, input int n);
    for (int i = 0; i < n; i++)
      parWrite(a + 6'(i), w[8*(n-1-i) +: 8]);
  endtask

  task automatic parRead(input logic [5:0] a, output logic [7:0] d);
    addrPin = a;
    csPinN = 1'b0;
    ticks(6);
    d = dataRd;
    csPinN = 1'b1;
    ticks(3);
  endtask

  task automatic strobeUpdate();
    updPin = 1'b1;
    ticks(4);
    updPin = 1'b0;
    ticks(4);
  endtask

  task automatic setKeys(input logic k, input logic s);
    keyPin = k;
    oskPin = s;
    ticks(4);
  endtask

  task automatic serialOpen();
    selectPin = 1'b0;
    addrPin = 6'h00;
    csPinN = 1'b0;
    ticks(3);
  endtask

  task automatic serialBits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      addrPin[0] = b[7-i];
      ticks(4);
      wrPin = 1'b1;
      ticks(4);
      wrPin = 1'b0;
    end
  endtask

  task automatic ioReset();
    addrPin[2] = 1'b1;
    ticks(4);
    addrPin[2] = 1'b0;
    ticks(4);
  endtask

  task automatic serialClose();
    csPinN = 1'b1;
    addrPin[0] = ~addrPin[0];
    ticks(3);
  endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the update strobe, programming ports and keying pins
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic selectPin, wrPin, csPinN, updPin, keyPin, oskPin;
  logic serialDataOut, serialDataOeN, dataOeN, updOut, updOeN;
  logic [5:0] addrPin;
  logic [7:0] dataPin, dataOut, rd;
  logic [47:0] tuningWord, phaseAccum, f1, f2, t0;
  logic [13:0] phaseOffset;
  logic [11:0] amplitude, quadOut;
  logic [31:0] lfsrState = 32'h0000000d;
  int errors = 0;
  int checkCount = 0;
  int cycles = 0;
  int n;

  always #50 clk = ~clk;

  dukp_host_model host (.clk(clk), .dataRd(dataOut), .selectPin(selectPin), .wrPin(wrPin), .csPinN(csPinN),
    .addrPin(addrPin), .dataPin(dataPin), .updPin(updPin), .keyPin(keyPin), .oskPin(oskPin));

  dukp_update_keying DUT (.clk(clk), .rst(rst), .serialParallelSelect(selectPin), .writeSerialClockPin(wrPin),
    .readChipSelectPinN(csPinN), .addrIn(addrPin), .serialDataOut(serialDataOut), .serialDataOeN(serialDataOeN),
    .dataIn(dataPin), .dataOut(dataOut), .dataOeN(dataOeN), .registerUpdateStrobeIn(updPin),
    .registerUpdateStrobeOut(updOut), .registerUpdateStrobeOeN(updOeN), .keyingSelectHoldPin(keyPin),
    .shapedKeyingPin(oskPin), .tuningWord(tuningWord), .phaseAccum(phaseAccum), .phaseOffset(phaseOffset),
    .amplitude(amplitude), .quadratureDacOutput(quadOut));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic wrapUp();
    if (errors == 0 && checkCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 15000)
    begin
      errors = errors + 1;
      wrapUp();
    end
  end

  task automatic checkVal(input string name, input logic [47:0] exp, input logic [47:0] got);
    checkCount++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic randWord(output logic [47:0] w);
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    w[47:16] = lfsrState;
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    w[15:0] = lfsrState[31:16];
  endtask

  function automatic logic [7:0] ctrlByte(input logic [2:0] mode, input logic shaped_keying_pin, input logic q);
    return {2'b00, mode, q, shaped_keying_pin, 1'b0};
  endfunction

  function automatic logic [47:0] expTuning(input logic [47:0] a, input logic [47:0] b, input logic k);
    return k ? b : a;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    host.ticks(4);
    checkVal("update enable", 48'h0, 48'(updOeN));
    checkVal("data enable", 48'h1, 48'(dataOeN));
    checkVal("amplitude idle", 48'(dukp_pkg::AMP_FULL), 48'(amplitude));
    host.parRead(dukp_pkg::ADDR_CTRL, rd);
    checkVal("ctrl default", 48'(dukp_pkg::CTRL_RESET), 48'(rd));
    host.parRead(dukp_pkg::ADDR_UPD_PERIOD, rd);
    checkVal("period default", 48'(dukp_pkg::UPD_PERIOD_RESET), 48'(rd));
    host.parWrite(dukp_pkg::ADDR_CTRL, ctrlByte(dukp_pkg::MODE_FSK, 1'b0, 1'b0));
    for (n = 0; n < 200 && updOut !== 1'b1; n++) host.ticks(1);
    for (n = 0; n < 20 && updOut === 1'b1; n++) host.ticks(1);
    checkVal("update pulse", 48'h8, 48'(n));
    host.ticks(70);
    checkVal("update enable", 48'h1, 48'(updOeN));
    randWord(f1);
    randWord(f2);
    host.parWord(dukp_pkg::ADDR_FREQ1, f1, 6);
    host.parWord(dukp_pkg::ADDR_FREQ2, f2, 6);
    checkVal("tuning early", 48'h0, tuningWord);
    host.parRead(dukp_pkg::ADDR_FREQ1, rd);
    checkVal("read early", 48'h0, 48'(rd));
    host.strobeUpdate();
    checkVal("tuning low", expTuning(f1, f2, 1'b0), tuningWord);
    host.setKeys(1'b1, 1'b0);
    checkVal("tuning high", expTuning(f1, f2, 1'b1), tuningWord);
    host.parRead(dukp_pkg::ADDR_FREQ1, rd);
    checkVal("read active", 48'(f1[47:40]), 48'(rd));
    host.setKeys(1'b0, 1'b0);
    host.parWrite(dukp_pkg::ADDR_CTRL, ctrlByte(dukp_pkg::MODE_BPSK, 1'b0, 1'b0));
    host.parWord(dukp_pkg::ADDR_PHASE1, f2, 2);
    host.parWord(dukp_pkg::ADDR_PHASE2, f1, 2);
    host.strobeUpdate();
    checkVal("phase low", 48'(f2[13:0]), 48'(phaseOffset));
    host.setKeys(1'b1, 1'b0);
    checkVal("phase high", 48'(f1[13:0]), 48'(phaseOffset));
    randWord(f2);
    host.parWrite(dukp_pkg::ADDR_CTRL, ctrlByte(dukp_pkg::MODE_CHIRP, 1'b0, 1'b0));
    host.parWord(dukp_pkg::ADDR_DELTA, f2, 6);
    host.strobeUpdate();
    t0 = tuningWord;
    host.ticks(20);
    checkVal("held sweep", t0, tuningWord);
    host.setKeys(1'b0, 1'b0);
    t0 = tuningWord;
    host.ticks(10);
    checkVal("sweep runs", 48'h1, 48'(tuningWord !== t0));
    host.setKeys(1'b1, 1'b0);
    t0 = tuningWord;
    host.ticks(10);
    checkVal("held again", t0, tuningWord);
    host.setKeys(1'b0, 1'b0);
    host.parWrite(dukp_pkg::ADDR_CTRL, ctrlByte(dukp_pkg::MODE_SINGLE, 1'b0, 1'b1));
    host.parWord(dukp_pkg::ADDR_QDAC, f2, 2);
    host.strobeUpdate();
    checkVal("quad user", 48'(f2[11:0]), 48'(quadOut));
    checkVal("amplitude off", 48'(dukp_pkg::AMP_FULL), 48'(amplitude));
    host.parWrite(dukp_pkg::ADDR_CTRL, ctrlByte(dukp_pkg::MODE_SINGLE, 1'b1, 1'b0));
    host.strobeUpdate();
    for (n = 0; n < 5000 && amplitude !== dukp_pkg::AMP_ZERO; n++) host.ticks(1);
    checkVal("ramp down", 48'(dukp_pkg::AMP_ZERO), 48'(amplitude));
    checkVal("down rate", 48'h1, 48'(n >= 4080 && n <= 4100));
    host.setKeys(1'b0, 1'b1);
    for (n = 0; n < 5000 && amplitude !== dukp_pkg::AMP_FULL; n++) host.ticks(1);
    checkVal("ramp up", 48'(dukp_pkg::AMP_FULL), 48'(amplitude));
    checkVal("up rate", 48'h1, 48'(n >= 4080 && n <= 4100));
    randWord(f1);
    host.serialOpen();
    host.serialBits(8'h5a, 3);
    host.ioReset();
    host.serialBits({2'b00, dukp_pkg::ADDR_FREQ1}, 8);
    for (n = 0; n < 6; n++) host.serialBits(f1[8*(5-n) +: 8], 8);
    host.serialClose();
    host.strobeUpdate();
    checkVal("serial tuning", f1, tuningWord);
    t0 = phaseAccum;
    host.ticks(1);
    checkVal("phase step", tuningWord, phaseAccum - t0);
    // Serial read of the first frequency byte, sampled while the serial clock is low
    host.serialOpen();
    host.serialBits({2'b10, dukp_pkg::ADDR_FREQ1}, 8);
    host.ticks(5);
    checkVal("serial out enable", 48'h0, 48'(serialDataOeN));
    for (n = 0; n < 8; n++)
    begin
      rd[7-n] = serialDataOut;
      host.serialBits(8'h00, 1);
      host.ticks(5);
    end
    host.serialClose();
    checkVal("serial read", 48'(f1[47:40]), 48'(rd));
    checkVal("serial out idle", 48'h1, 48'(serialDataOeN));
    host.parWrite(dukp_pkg::ADDR_FREQ1, ~f1[47:40]);
    host.strobeUpdate();
    checkVal("serial mode strobe", f1, tuningWord);
    wrapUp();
  end
endmodule
